// *** core/irt_core.sv ***
// Purpose: 8-bit ir counter/timer control with wishbone register slave
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes:   sixteen-bit timer output arrives as a plain input
// Operation
// - control bit 7 reads run state; write 0 stops, write 1 starts
// - control bit 6: 0 modulo-N repeat, 1 single pass
// - control bits 4:3 pick clock undivided, /2, /4 or /8
// - capture interrupt raised per capture when bit 2 set
// - timeout interrupt raised per timeout when mask bit set
// - a control bit picks port output or timer output on pin
// - shared bit 7: 0 transmit mode, 1 demodulation mode
// - shared bit 6: output pin select or demodulator input select
// - shared bits 5:4: AND/OR/NOR/NAND combine or edge type
// - wrap from zero to all-ones is no timeout
// - stop and flag clear act after one count clock interval
// - demod: idle after enable until first selected edge starts count
// - demod: later selected edges store inverted count in capture
// - full reset clears control; stop recovery clears bits 7,6,0
// - shared register cleared; stop recovery keeps bits 5,4
// - sixteen-bit control cleared; stop recovery keeps bits 5:2
// - combined control resets to 1Fh; stop recovery keeps bit 5
// - four hold registers clear on reset, kept on stop recovery
// - high and low hold registers are 8-bit read/write reload values
// - control bit 5 set on timeout; write 1 clears, 0 no effect
// - bit 1 timeout interrupt enable; bit 0 pin timer output
`timescale 1ns/1ps
`include "irt_cfg.svh"
module irt_core
  import irt_pkg::*;
(
  // clock and resets
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        stop_recover_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // pins and companion timer
  input  wire logic        port_out_i,
  input  wire logic        t16_out_i,
  input  wire logic        port3_bit1_pin_i,
  input  wire logic        port2_bit0_pin_i,
  output logic             port3_bit4_pin_o,
  output logic             port3_bit6_pin_o,
  output logic             port3_bit6_oe_o,
  output logic             irq_o
);
  irt_state_s s_ff;
  irt_state_s nxt_s;
  logic       tick;
  logic       req;
  logic       wr;
  logic [3:0] idx;
  logic       demod;
  logic       edge_rise;
  logic       edge_fall;
  logic       edge_sel;
  logic       timeout;
  logic       cap_ev;
  logic       comb_out;
  logic [7:0] rd;
  logic [1:0] es;

  // ==========================================================================
  // decode and count clock enable
  assign req   = cyc_i & stb_i & ~s_ff.ack;
  assign wr    = req & we_i & sel_i[0];
  assign idx   = adr_i[5:2];
  assign demod = s_ff.r.shared[`IRT_B_DEMOD];
  assign es    = s_ff.r.shared[5:4];
  always_comb begin
    case (s_ff.r.ctl8[4:3])
      2'h0:    tick = 1'b1;
      2'h1:    tick = s_ff.div[0];
      2'h2:    tick = &s_ff.div[1:0];
      default: tick = &s_ff.div;
    endcase
  end

  // ==========================================================================
  // edge detection on the synchronised demodulator input
  // only sync[2:1] agreeing counts, sync[0] feeds sync[1] only
  assign edge_rise = (s_ff.sync[2] == s_ff.sync[1]) & s_ff.sync[1]
                     & ~s_ff.din;
  assign edge_fall = (s_ff.sync[2] == s_ff.sync[1]) & ~s_ff.sync[1]
                     & s_ff.din;
  always_comb begin
    case (es)
      2'h0:    edge_sel = edge_fall;
      2'h1:    edge_sel = edge_rise;
      2'h2:    edge_sel = edge_rise | edge_fall;
      default: edge_sel = 1'b0;
    endcase
  end

  // count ends at 1 -> 0; the 0 -> FF wrap is never a timeout
  assign timeout = tick & (s_ff.st == ST_COUNT)
                   & (s_ff.cnt == 8'h01);
  assign cap_ev  = demod & (s_ff.st == ST_COUNT) & edge_sel;

  always_comb begin
    case (es)
      2'h0:    comb_out = s_ff.lvl & t16_out_i;
      2'h1:    comb_out = s_ff.lvl | t16_out_i;
      2'h2:    comb_out = ~(s_ff.lvl | t16_out_i);
      default: comb_out = ~(s_ff.lvl & t16_out_i);
    endcase
  end

  // ==========================================================================
  // read mux
  always_comb begin
    case (idx)
      {1'b0, `IRT_IDX_CTL8}:   rd = s_ff.r.ctl8;
      {1'b0, `IRT_IDX_SHARED}: rd = s_ff.r.shared;
      {1'b0, `IRT_IDX_CTL16}:  rd = s_ff.r.ctl16;
      {1'b0, `IRT_IDX_COMB}:   rd = s_ff.r.comb;
      {1'b0, `IRT_IDX_LOHOLD}: rd = s_ff.r.lohold;
      {1'b0, `IRT_IDX_HIHOLD}: rd = s_ff.r.hihold;
      {1'b0, `IRT_IDX_LO16}:   rd = s_ff.r.lo16;
      {1'b0, `IRT_IDX_HI16}:   rd = s_ff.r.hi16;
      `IRT_IDX_CAPLO:          rd = s_ff.cap_lo;
      `IRT_IDX_CAPHI:          rd = s_ff.cap_hi;
      `IRT_IDX_STAT:           rd = {6'h00, s_ff.st};
      default:                 rd = 8'h00;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.sync = {s_ff.sync[1:0], demod & s_ff.r.shared[`IRT_B_PIN2] ?
                  port2_bit0_pin_i : port3_bit1_pin_i};
    if (s_ff.sync[2] == s_ff.sync[1])
      nxt_s.din = s_ff.sync[1];
    nxt_s.div = s_ff.div + 3'h1;
    nxt_s.ack = req;
    nxt_s.dat = {24'h000000, rd};
    // register writes
    if (wr) begin
      case (idx)
        {1'b0, `IRT_IDX_CTL8}: begin
          nxt_s.r.ctl8[`IRT_B_SINGLE] = dat_i[`IRT_B_SINGLE];
          nxt_s.r.ctl8[4:0] = dat_i[4:0];
          if (dat_i[`IRT_B_RUN] && !s_ff.r.ctl8[`IRT_B_RUN]) begin
            nxt_s.r.ctl8[`IRT_B_RUN] = 1'b1;
            nxt_s.st  = demod ? ST_WAIT_EDGE : ST_COUNT;
            nxt_s.cnt = s_ff.r.lohold;
            nxt_s.lvl = 1'b0;
            nxt_s.stop_pend = 1'b0;
          end else if (!dat_i[`IRT_B_RUN] && s_ff.r.ctl8[`IRT_B_RUN])
            nxt_s.stop_pend = 1'b1;
          if (dat_i[`IRT_B_TOUT])
            nxt_s.clr_pend = 1'b1;
        end
        {1'b0, `IRT_IDX_SHARED}: nxt_s.r.shared = dat_i[7:0];
        {1'b0, `IRT_IDX_CTL16}:  nxt_s.r.ctl16  = dat_i[7:0];
        {1'b0, `IRT_IDX_COMB}:   nxt_s.r.comb   = dat_i[7:0];
        {1'b0, `IRT_IDX_LOHOLD}: nxt_s.r.lohold = dat_i[7:0];
        {1'b0, `IRT_IDX_HIHOLD}: nxt_s.r.hihold = dat_i[7:0];
        {1'b0, `IRT_IDX_LO16}:   nxt_s.r.lo16   = dat_i[7:0];
        {1'b0, `IRT_IDX_HI16}:   nxt_s.r.hi16   = dat_i[7:0];
        default: ;
      endcase
    end
    // deferred stop and clear land on the next count clock tick
    if (tick && s_ff.stop_pend) begin
      nxt_s.stop_pend = 1'b0;
      nxt_s.r.ctl8[`IRT_B_RUN] = 1'b0;
      nxt_s.st = ST_IDLE;
    end
    if (tick && s_ff.clr_pend) begin
      nxt_s.clr_pend = 1'b0;
      nxt_s.r.ctl8[`IRT_B_TOUT] = 1'b0;
    end
    // counter
    case (s_ff.st)
      ST_IDLE: ;
      ST_WAIT_EDGE:
        if (edge_sel)
          nxt_s.st = ST_COUNT;
      ST_COUNT: begin
        if (cap_ev) begin
          if (edge_rise)
            nxt_s.cap_lo = ~s_ff.cnt;
          else
            nxt_s.cap_hi = ~s_ff.cnt;
          nxt_s.cnt = s_ff.r.lohold;
        end else if (tick) begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
          if (timeout) begin
            nxt_s.lvl = ~s_ff.lvl;
            nxt_s.cnt = s_ff.lvl ? s_ff.r.lohold : s_ff.r.hihold;
            if (demod)
              nxt_s.st = ST_WAIT_EDGE;
            else if (s_ff.r.ctl8[`IRT_B_SINGLE])
              nxt_s.st = ST_DONE;
          end
        end
      end
      ST_DONE: ;
      default: nxt_s.st = ST_IDLE;
    endcase
    // set wins over a clear landing in the same cycle
    if (timeout)
      nxt_s.r.ctl8[`IRT_B_TOUT] = 1'b1;
    nxt_s.irq = (timeout & s_ff.r.ctl8[`IRT_B_TOIE])
              | (cap_ev & s_ff.r.ctl8[`IRT_B_CAPIE]);
    nxt_s.pin = s_ff.r.ctl8[`IRT_B_PINSEL] ? s_ff.lvl : port_out_i;
    nxt_s.pin_oe = ~demod;
    if (!demod && s_ff.r.shared[`IRT_B_PIN2])
      nxt_s.pin_oe = 1'b1;
    // registered so the pin never glitches on the companion input
    nxt_s.pin6 = (~demod & s_ff.r.shared[`IRT_B_PIN2])
                 ? comb_out : port_out_i;
    nxt_s.lvl = nxt_s.lvl;
    // stop-mode recovery keeps only the documented bits
    if (stop_recover_i) begin
      nxt_s.r.ctl8   = s_ff.r.ctl8 & `IRT_KEEP_CTL8;
      nxt_s.r.shared = s_ff.r.shared & `IRT_KEEP_SHARED;
      nxt_s.r.ctl16  = s_ff.r.ctl16 & `IRT_KEEP_CTL16;
      nxt_s.r.comb   = (s_ff.r.comb & `IRT_KEEP_COMB)
                     | (`IRT_RST_COMB & ~`IRT_KEEP_COMB);
      nxt_s.st = ST_IDLE;
      nxt_s.stop_pend = 1'b0;
      nxt_s.clr_pend  = 1'b0;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff        <= '0;
      s_ff.r.comb <= `IRT_RST_COMB;
      s_ff.st     <= ST_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // combined timer output drives the pin when selected in transmit mode
  assign port3_bit6_pin_o = s_ff.pin6;
  assign port3_bit4_pin_o = s_ff.pin;
  assign port3_bit6_oe_o  = s_ff.pin_oe;
  assign irq_o            = s_ff.irq;
  assign ack_o            = s_ff.ack;
  assign dat_o            = s_ff.dat;

  // ==========================================================================
  // checks
  sequence SEQ_STOP_WR;
    wr && idx == 4'h0 && !dat_i[7] && s_ff.r.ctl8[7];
  endsequence
  AST_RUN_AFTER_RESET: assert property (@(posedge clk_i)
    $fell(rst_i) |-> !s_ff.r.ctl8[7]) else $error("run set after reset");
  AST_STOP_DEFERRED: assert property (@(posedge clk_i) disable iff (rst_i)
    SEQ_STOP_WR ##1 !stop_recover_i |-> s_ff.r.ctl8[7])
    else $error("stop took effect at once");
  AST_NO_WRAP_TOUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_ff.cnt == 8'h00 && s_ff.st == ST_COUNT) |-> !timeout)
    else $error("wrap counted as timeout");
  AST_TOUT_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    timeout && !stop_recover_i |=> s_ff.r.ctl8[5])
    else $error("timeout flag not set");
  AST_TOUT_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> $past(timeout & s_ff.r.ctl8[1] | cap_ev & s_ff.r.ctl8[2]))
    else $error("spurious interrupt");
  AST_CAP_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_ev && s_ff.r.ctl8[2] |=> irq_o)
    else $error("capture interrupt missing");
  AST_CAP_VAL: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_ev && edge_rise && !stop_recover_i |=> s_ff.cap_lo ==
    ~$past(s_ff.cnt)) else $error("capture value wrong");
  AST_DEMOD_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ff.st == ST_WAIT_EDGE && !edge_sel && !stop_recover_i && !wr &&
    !(tick && s_ff.stop_pend)
    |=> s_ff.st == ST_WAIT_EDGE)
    else $error("count began without edge");
  AST_COMB_RST: assert property (@(posedge clk_i)
    $fell(rst_i) |-> s_ff.r.comb == 8'h1F) else $error("comb reset");
endmodule

// *** core/irt_cfg.svh ***
// Purpose: offsets, field positions, reset values of the ir timer block
// Assumes: byte offsets are word indexes; byte address = index * 4
// Notes:   included by the core and the bench
`ifndef IRT_CFG_SVH
`define IRT_CFG_SVH
// ==========================================================================
// register indexes
`define IRT_IDX_CTL8      3'h0
`define IRT_IDX_SHARED    3'h1
`define IRT_IDX_CTL16     3'h2
`define IRT_IDX_COMB      3'h3
`define IRT_IDX_LOHOLD    3'h4
`define IRT_IDX_HIHOLD    3'h5
`define IRT_IDX_LO16      3'h6
`define IRT_IDX_HI16      3'h7
`define IRT_IDX_CAPLO     4'h8
`define IRT_IDX_CAPHI     4'h9
`define IRT_IDX_STAT      4'hA
// ==========================================================================
// control bit positions
`define IRT_B_RUN         7
`define IRT_B_SINGLE      6
`define IRT_B_TOUT        5
`define IRT_B_CAPIE       2
`define IRT_B_TOIE        1
`define IRT_B_PINSEL      0
`define IRT_B_DEMOD       7
`define IRT_B_PIN2        6
// ==========================================================================
// reset values and stop-recovery keep masks
`define IRT_RST_COMB      8'h1F
`define IRT_KEEP_CTL8     8'h3E
`define IRT_KEEP_SHARED   8'h30
`define IRT_KEEP_CTL16    8'h3C
`define IRT_KEEP_COMB     8'h20
`define IRT_ALL_ONES      8'hFF
`endif

// *** core/irt_pkg.sv ***
// Purpose: types of the ir timer block
// Assumes: irt_cfg.svh holds the numbers
// Notes:   state of the core is one packed struct
package irt_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EDGE, ST_COUNT, ST_DONE} irt_e;
  typedef struct packed {
    logic [7:0] ctl8;
    logic [7:0] shared;
    logic [7:0] ctl16;
    logic [7:0] comb;
    logic [7:0] lohold;
    logic [7:0] hihold;
    logic [7:0] lo16;
    logic [7:0] hi16;
  } irt_regs_s;
  typedef struct packed {
    irt_regs_s  r;
    logic [7:0] cap_lo;
    logic [7:0] cap_hi;
    logic [7:0] cnt;
    logic       lvl;
    irt_e       st;
    logic [2:0] div;
    logic       stop_pend;
    logic       clr_pend;
    logic [2:0] sync;
    logic       din;
    logic       ack;
    logic [31:0] dat;
    logic       irq;
    logic       pin;
    logic       pin6;
    logic       pin_oe;
  } irt_state_s;
endpackage

// *** test/irt_pulse_src.sv ***
// Purpose: pulse train source on the two demodulator input pins
// Assumes: gap counted in system clock cycles, idle level high
// Notes:   unselected pin toggles each cycle so a wrong pick is seen
`timescale 1ns/1ps
module irt_pulse_src (
  // clock and control
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic       sel_i,
  input  wire logic [7:0] gap_i,
  // pins
  output logic            port3_bit1_pin_o,
  output logic            port2_bit0_pin_o
);
  logic [7:0] cnt_ff;
  logic       lvl_ff;
  logic       junk_ff;
  initial begin
    cnt_ff = 8'h00;
    lvl_ff = 1'b1;
    junk_ff = 1'b0;
  end
  // ===========================================================
  // pulse timing
  always @(posedge clk_i) begin
    junk_ff <= ~junk_ff;
    if (!en_i) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff == gap_i - 8'h01) begin
      cnt_ff <= 8'h00;
      lvl_ff <= ~lvl_ff;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  assign port3_bit1_pin_o = sel_i ? junk_ff : lvl_ff;
  assign port2_bit0_pin_o = sel_i ? lvl_ff : junk_ff;
endmodule

// *** test/irt_core_bench.sv ***
// Purpose: self-checking bench for the ir timer control block
// Assumes: one 8-bit register per word, reads answered with ack
// Notes:   divider judged by ratios of timeout periods, not counts
`timescale 1ns/1ps
`include "irt_cfg.svh"
module irt_core_bench;
  logic        clk_i, rst_i, src_i, cyc_i, stb_i, we_i;
  logic        port_out_i, other_out, ack_o, irq_o, pin4_o, pin6_o, oe6_o;
  logic        dem_a, dem_b, pen, psel;
  logic [5:0]  adr_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0]  gap, q, n, lo, v[8];
  logic [1:0]  op;
  int          failures, n_tests, irqs, t0, t1, p[4];
  logic [7:0]  keep[8] = '{8'h3E, 8'h30, 8'h3C, 8'h20, 8'hFF, 8'hFF,
                           8'hFF, 8'hFF};
  logic [7:0]  ctab[3] = '{8'h83, 8'hC3, 8'h81};
  logic [7:0]  etab[3] = '{8'h02, 8'h01, 8'h00};

  irt_core dut (.clk_i(clk_i), .rst_i(rst_i), .stop_recover_i(src_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .port_out_i(port_out_i), .t16_out_i(other_out),
    .port3_bit1_pin_i(dem_a), .port2_bit0_pin_i(dem_b),
    .port3_bit4_pin_o(pin4_o), .port3_bit6_pin_o(pin6_o),
    .port3_bit6_oe_o(oe6_o), .irq_o(irq_o));
  irt_pulse_src src (.clk_i(clk_i), .en_i(pen), .sel_i(psel),
    .gap_i(gap), .port3_bit1_pin_o(dem_a), .port2_bit0_pin_o(dem_b));

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (irq_o === 1'b1) begin
      irqs <= irqs + 1;
      t0 <= t1;
      t1 <= int'($time);
    end
  end
  // ===========================================================
  // helpers
  function automatic logic comb_fn(input logic [1:0] o, input logic a,
                                   input logic b);
    case (o)
      2'b00: return a & b;
      2'b01: return a | b;
      2'b10: return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction
  function automatic logic [7:0] near(input logic [7:0] a, input logic [7:0] b);
    return {7'h00, (a - b + 8'h03) <= 8'h06};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [3:0] idx, input logic w, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 64);
    chk({7'h00, k < 64}, 8'h01);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // stop first, clear the flag in a later write
  task automatic stop_clr();
    wb(`IRT_IDX_CTL8, 1'b1, 8'h00);
    repeat (20) @(posedge clk_i);
    wb(`IRT_IDX_CTL8, 1'b0, 8'h00);
    chk({q[7], q[5]}, 8'h01);
    wb(`IRT_IDX_CTL8, 1'b1, 8'h20);
    repeat (20) @(posedge clk_i);
    wb(`IRT_IDX_CTL8, 1'b0, 8'h00);
    chk({7'h00, q[5]}, 8'h00);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
  // ===========================================================
  // main sequence
  initial begin
    {clk_i, src_i, cyc_i, stb_i, we_i, port_out_i, other_out} = '0;
    {pen, psel, adr_i, dat_i, gap, irqs, t0, t1} = '0;
    rst_i = 1'b1;
    failures = 0;
    n_tests = 0;
    void'($urandom(88));
    do_reset();
    for (int i = 0; i < 10; i++) begin
      wb(i[3:0], 1'b0, 8'h00);
      chk(q, (i == 3) ? `IRT_RST_COMB : 8'h00);
    end
    wb(4'hB, 1'b1, 8'h5A);
    wb(4'hB, 1'b0, 8'h00);
    chk(q, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v[i] = 8'($urandom) & ((i == 0) ? 8'h1F : 8'hFF);
      wb(i[3:0], 1'b1, v[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wb(i[3:0], 1'b0, 8'h00);
      chk(q, v[i]);
    end
    @(posedge clk_i);
    src_i <= 1'b1;
    @(posedge clk_i);
    src_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wb(i[3:0], 1'b0, 8'h00);
      chk(q, (v[i] & keep[i]) | ((i == 3) ? 8'h1F & ~keep[i] : 8'h00));
    end
    // timeouts: modulo-N, single pass, masked
    do_reset();
    n = 8'h04 + 8'($urandom % 12);
    wb(`IRT_IDX_LOHOLD, 1'b1, n);
    wb(`IRT_IDX_HIHOLD, 1'b1, n);
    for (int m = 0; m < 3; m++) begin
      irqs = 0;
      wb(`IRT_IDX_CTL8, 1'b1, ctab[m]);
      repeat (300) @(posedge clk_i);
      chk(8'((irqs > 2) ? 2 : irqs), etab[m]);
      stop_clr();
    end
    for (int d = 0; d < 4; d++) begin
      wb(`IRT_IDX_CTL8, 1'b1, 8'h82 | 8'(d << 3));
      repeat (100 << d) @(posedge clk_i);
      p[d] = t1 - t0;
      stop_clr();
      if (d > 0) chk({7'h00, p[d] == (p[0] << d)}, 8'h01);
    end
    // output selection and combining; reset puts the timer level at 0
    do_reset();
    for (int k = 0; k < 8; k++) begin
      op = k[1:0];
      other_out <= op[0] ^ op[1];
      port_out_i <= 1'($urandom);
      wb(`IRT_IDX_SHARED, 1'b1, {1'b0, k[2], op, 4'h0});
      repeat (4) @(posedge clk_i);
      if (k[2]) chk({7'h00, pin6_o}, {7'h00, comb_fn(op, 1'b0, other_out)});
      else chk({6'h00, pin6_o, pin4_o}, {6'h00, port_out_i, port_out_i});
    end
    // demodulation captures, last pass with capture interrupt masked
    for (int e = 0; e < 4; e++) begin
      do_reset();
      op = (e == 3) ? 2'b10 : 2'(e);
      wb(`IRT_IDX_LOHOLD, 1'b1, `IRT_ALL_ONES);
      wb(`IRT_IDX_HIHOLD, 1'b1, `IRT_ALL_ONES);
      psel <= (e == 1);
      gap <= 8'd40;
      wb(`IRT_IDX_SHARED, 1'b1, {1'b1, e == 1, op, 4'h0});
      irqs = 0;
      wb(`IRT_IDX_CTL8, 1'b1, (e == 3) ? 8'h80 : 8'h84);
      pen <= 1'b1;
      repeat (500) @(posedge clk_i);
      pen <= 1'b0;
      wb(`IRT_IDX_CTL8, 1'b1, 8'h00);
      chk({7'h00, irqs > 0}, {7'h00, e < 3});
      wb(`IRT_IDX_CAPLO, 1'b0, 8'h00);
      lo = q;
      wb(`IRT_IDX_CAPHI, 1'b0, 8'h00);
      chk(near(lo, (op == 2'b00) ? 8'd0 : ((op == 2'b01) ? 8'd80 : 8'd40)), 8'h01);
      chk(near(q, (op == 2'b01) ? 8'd0 : ((op == 2'b00) ? 8'd80 : 8'd40)), 8'h01);
    end
    wrap_up();
  end
endmodule
